// [core/fetch_pipe_pkg.sv]
// Constants for the instruction fetch and execute sequencer.
// Assumes one core clock; the four phases are derived inside the block.
package fetch_pipe_pkg;

  // ---------------------------------------------------------------
  // Phases, Gray coded along the cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } phase_e;

  // ---------------------------------------------------------------
  // Two-word instruction kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TW_GOTO, TW_CALL, TW_MOVE_FF, TW_LOAD_PTR,
    TW_ADD_LINK, TW_CALL_W, TW_MOVE_SS, TW_SUB_LINK
  } two_word_e;

  // ---------------------------------------------------------------
  // Opcodes and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] NOP_WORD       = 16'h0000;
  localparam logic [3:0]  SECOND_NIBBLE  = 4'hF;
  localparam logic [5:0]  OP_ADD_W_FILE  = 6'h09;
  localparam logic [6:0]  OP_MOVE_W_FILE = 7'h37;
  localparam logic [6:0]  OP_TEST_SKIP   = 7'h33;
  localparam logic [7:0]  OP_MOVE_LIT    = 8'h0E;
  localparam logic [7:0]  OP_RET_LIT     = 8'h0C;
  localparam logic [4:0]  OP_BRANCH      = 5'h1A;
  localparam logic [15:0] OP_TABLE_READ  = 16'h0008;
  localparam logic [15:0] OP_TABLE_WRITE = 16'h000C;
  localparam logic [15:0] OP_CALL_W      = 16'h0014;

  // ---------------------------------------------------------------
  // Core registers held inside the block, by data address
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_PC_LOW    = 12'hFF9;
  localparam logic [11:0] ADDR_PC_HIGH   = 12'hFFA;
  localparam logic [11:0] ADDR_PC_UPPER  = 12'hFFB;
  localparam logic [11:0] ADDR_TBL_LOW   = 12'hFF6;
  localparam logic [11:0] ADDR_TBL_HIGH  = 12'hFF7;
  localparam logic [11:0] ADDR_TBL_UPPER = 12'hFF8;
  localparam logic [11:0] ADDR_TBL_LATCH = 12'hFF5;
  localparam logic [11:0] ADDR_WORKING   = 12'hFE8;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_BANK_HI = 4'hF;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [19:0] PC_WORD_RESET  = 20'h00000;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [3:0]  STROBE_RESET   = 4'h1;

endpackage

// [core/fetch_pipeline.sv]
// Four-phase instruction sequencer with a two-stage fetch/execute pipeline.
// Assumes program and data memories answer within one phase, on core_clk.
`timescale 1ns/1ps

module fetch_pipeline
  import fetch_pipe_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Program memory fetch
  output wire logic [20:0] pm_addr,
  input  wire logic [15:0] pm_rdata,
  // Table access to program memory
  output wire logic [20:0] tbl_addr,
  output wire logic        tbl_rd_en,
  input  wire logic [7:0]  tbl_rdata,
  output wire logic        tbl_wr_en,
  output wire logic [7:0]  tbl_wdata,
  // Data memory
  input  wire logic [3:0]  bank_sel,
  output wire logic [11:0] dm_addr,
  output wire logic        dm_rd_en,
  input  wire logic [7:0]  dm_rdata,
  output wire logic        dm_wr_en,
  output wire logic [7:0]  dm_wdata,
  // Return stack outside the block
  output wire logic        stack_push,
  output wire logic [20:0] push_addr,
  output wire logic        stack_pop,
  input  wire logic [20:0] pop_addr,
  // Phase strobes, one-hot, bit 0 is phase one
  output wire logic [3:0]  phase_strobe
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f, input logic [3:0] bank);
    if (a) begin
      file_addr = {bank, f};
    end else begin
      file_addr = (f >= ACCESS_SPLIT) ? {ACCESS_BANK_HI, f} : {4'h0, f};
    end
  endfunction

  function automatic logic is_core_reg(input logic [11:0] a);
    is_core_reg = (a == ADDR_PC_LOW) || (a == ADDR_PC_HIGH) || (a == ADDR_PC_UPPER) ||
                  (a == ADDR_TBL_LOW) || (a == ADDR_TBL_HIGH) || (a == ADDR_TBL_UPPER) ||
                  (a == ADDR_TBL_LATCH) || (a == ADDR_WORKING);
  endfunction

  // Returns {valid, kind} for the first word of a two-word instruction
  function automatic logic [3:0] two_word_kind(input logic [15:0] w);
    two_word_kind = 4'h0;
    if (w[15:8] == 8'hEF) two_word_kind = {1'b1, TW_GOTO};
    if (w[15:9] == 7'h76) two_word_kind = {1'b1, TW_CALL};
    if (w[15:12] == 4'hC) two_word_kind = {1'b1, TW_MOVE_FF};
    if (w[15:6] == 10'h3B8) two_word_kind = {1'b1, TW_LOAD_PTR};
    if (w[15:6] == 10'h3A3) two_word_kind = {1'b1, TW_ADD_LINK};
    if (w == OP_CALL_W) two_word_kind = {1'b1, TW_CALL_W};
    if (w[15:7] == 9'h1D7) two_word_kind = {1'b1, TW_MOVE_SS};
    if (w[15:6] == 10'h3A7) two_word_kind = {1'b1, TW_SUB_LINK};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  phase_e      phase_q;
  phase_e      phase_d;
  logic [3:0]  strobe_q;
  logic [19:0] pc_word_q;
  logic [19:0] pc_word_d;
  logic [15:0] fetch_q;
  logic [15:0] ir_q;
  logic [15:0] ir_d;
  logic        pend_q;
  two_word_e   pend_kind_q;
  logic [7:0]  pend_lit_q;
  logic [7:0]  w_q;
  logic [7:0]  pch_q;
  logic [4:0]  pcu_q;
  logic [20:0] table_pointer_q;
  logic [7:0]  table_latch_q;
  logic [7:0]  operand_q;
  logic [11:0] dm_addr_q;
  logic        dm_rd_en_q;
  logic        dm_wr_en_q;
  logic [7:0]  dm_wdata_q;
  logic        tbl_rd_en_q;
  logic        tbl_wr_en_q;
  logic        push_q;
  logic        pop_q;
  logic [19:0] push_word_q;

  // ---------------------------------------------------------------
  // Phase divider
  // ---------------------------------------------------------------
  always_comb begin
    unique case (phase_q)
      PH_ONE:   phase_d = PH_TWO;
      PH_TWO:   phase_d = PH_THREE;
      PH_THREE: phase_d = PH_FOUR;
      PH_FOUR:  phase_d = PH_ONE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q  <= PH_ONE;
      strobe_q <= STROBE_RESET;
    end else begin
      phase_q  <= phase_d;
      strobe_q <= {strobe_q[2:0], strobe_q[3]};
    end
  end

  wire at_one   = (phase_q == PH_ONE);
  wire at_two   = (phase_q == PH_TWO);
  wire at_three = (phase_q == PH_THREE);
  wire at_four  = (phase_q == PH_FOUR);

  // ---------------------------------------------------------------
  // Decode of the executing word
  // ---------------------------------------------------------------
  wire [3:0]  first_info = two_word_kind(ir_q);
  wire        sec_word   = (ir_q[15:12] == SECOND_NIBBLE);
  // A second word with no first word ahead of it matches nothing below
  wire        sec_ok     = sec_word && pend_q;
  wire        is_first   = first_info[3] && !sec_word;
  wire        is_add     = (ir_q[15:10] == OP_ADD_W_FILE);
  wire        is_movwf   = (ir_q[15:9] == OP_MOVE_W_FILE);
  wire        is_tstfsz  = (ir_q[15:9] == OP_TEST_SKIP);
  wire        is_movlw   = (ir_q[15:8] == OP_MOVE_LIT);
  wire        is_ret_lit = (ir_q[15:8] == OP_RET_LIT);
  wire        is_bra     = (ir_q[15:11] == OP_BRANCH);
  wire        is_tblrd   = (ir_q == OP_TABLE_READ);
  wire        is_tblwt   = (ir_q == OP_TABLE_WRITE);
  wire [11:0] f_addr     = file_addr(ir_q[8], ir_q[7:0], bank_sel);
  wire        mov_first  = is_first && (first_info[2:0] == TW_MOVE_FF);
  wire        mov_second = sec_ok && (pend_kind_q == TW_MOVE_FF);
  wire        jump_sec   = sec_ok && (pend_kind_q == TW_GOTO || pend_kind_q == TW_CALL);

  wire [11:0] rd_addr    = mov_first ? ir_q[11:0] : f_addr;
  wire        rd_need    = is_add || is_tstfsz || mov_first;
  wire [7:0]  sum        = 8'(operand_q + w_q);
  wire        wr_need    = (is_add && ir_q[9]) || is_movwf || mov_second;
  wire [11:0] wr_addr    = mov_second ? ir_q[11:0] : f_addr;
  wire [7:0]  wr_data    = is_add ? sum : (is_movwf ? w_q : operand_q);
  wire        low_write  = wr_need && (wr_addr == ADDR_PC_LOW);
  wire        low_read   = rd_need && (rd_addr == ADDR_PC_LOW) && !low_write;

  wire [7:0]  core_rdata =
    (rd_addr == ADDR_PC_LOW)    ? {pc_word_q[6:0], 1'b0} :
    (rd_addr == ADDR_PC_HIGH)   ? pch_q :
    (rd_addr == ADDR_PC_UPPER)  ? {3'h0, pcu_q} :
    (rd_addr == ADDR_TBL_LOW)   ? table_pointer_q[7:0] :
    (rd_addr == ADDR_TBL_HIGH)  ? table_pointer_q[15:8] :
    (rd_addr == ADDR_TBL_UPPER) ? {3'h0, table_pointer_q[20:16]} :
    (rd_addr == ADDR_TBL_LATCH) ? table_latch_q : w_q;

  // ---------------------------------------------------------------
  // Program flow
  // ---------------------------------------------------------------
  wire [19:0] bra_offset = {{9{ir_q[10]}}, ir_q[10:0]};
  wire        skip       = is_tstfsz && (operand_q == BYTE_RESET);
  wire        flow       = is_bra || jump_sec || is_ret_lit || low_write;
  wire        flush      = flow || skip;
  // The low bit of a computed offset is dropped; it must be even
  wire [19:0] target     =
    is_bra   ? pc_word_q + bra_offset :
    jump_sec ? {ir_q[11:0], pend_lit_q} :
    is_ret_lit ? pop_addr[20:1] : {pcu_q, pch_q, wr_data[7:1]};

  assign pc_word_d = flow ? target : pc_word_q + 20'h00001;
  assign ir_d      = flush ? NOP_WORD : fetch_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_word_q <= PC_WORD_RESET;
      fetch_q   <= NOP_WORD;
      ir_q      <= NOP_WORD;
    end else begin
      if (at_three) fetch_q <= pm_rdata;
      if (at_four) begin
        pc_word_q <= pc_word_d;
        ir_q      <= ir_d;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q      <= 1'b0;
      pend_kind_q <= TW_GOTO;
      pend_lit_q  <= BYTE_RESET;
    end else if (at_four) begin
      pend_q      <= is_first;
      pend_kind_q <= two_word_e'(first_info[2:0]);
      pend_lit_q  <= ir_q[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Data memory strobes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dm_addr_q  <= 12'h000;
      dm_rd_en_q <= 1'b0;
      dm_wr_en_q <= 1'b0;
      dm_wdata_q <= BYTE_RESET;
    end else begin
      dm_rd_en_q <= at_one && rd_need && !is_core_reg(rd_addr);
      dm_wr_en_q <= at_three && wr_need && !is_core_reg(wr_addr);
      if (at_one) dm_addr_q <= rd_addr;
      if (at_three) begin
        dm_addr_q  <= wr_addr;
        dm_wdata_q <= wr_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      operand_q <= BYTE_RESET;
    end else if (at_two && rd_need) begin
      operand_q <= is_core_reg(rd_addr) ? core_rdata : dm_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Core registers: working register, PC latches, table path
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_q <= BYTE_RESET;
    end else if (at_four) begin
      if (is_movlw || is_ret_lit) w_q <= ir_q[7:0];
      else if (is_add && !ir_q[9]) w_q <= sum;
      else if (wr_need && wr_addr == ADDR_WORKING) w_q <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pch_q <= BYTE_RESET;
      pcu_q <= 5'h00;
    end else if (at_two && low_read) begin
      pch_q <= pc_word_q[14:7];
      pcu_q <= pc_word_q[19:15];
    end else if (at_four && wr_need) begin
      if (wr_addr == ADDR_PC_HIGH) pch_q <= wr_data;
      if (wr_addr == ADDR_PC_UPPER) pcu_q <= wr_data[4:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_pointer_q <= 21'h000000;
      table_latch_q   <= BYTE_RESET;
      tbl_rd_en_q     <= 1'b0;
      tbl_wr_en_q     <= 1'b0;
    end else begin
      tbl_rd_en_q <= at_one && is_tblrd;
      tbl_wr_en_q <= at_three && is_tblwt;
      if (at_two && is_tblrd) table_latch_q <= tbl_rdata;
      if (at_four && wr_need) begin
        if (wr_addr == ADDR_TBL_LOW) table_pointer_q[7:0] <= wr_data;
        if (wr_addr == ADDR_TBL_HIGH) table_pointer_q[15:8] <= wr_data;
        if (wr_addr == ADDR_TBL_UPPER) table_pointer_q[20:16] <= wr_data[4:0];
        if (wr_addr == ADDR_TBL_LATCH) table_latch_q <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Return stack handshake
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      push_q      <= 1'b0;
      pop_q       <= 1'b0;
      push_word_q <= PC_WORD_RESET;
    end else begin
      push_q <= at_four && sec_ok && pend_kind_q == TW_CALL;
      pop_q  <= at_three && is_ret_lit;
      if (at_four) push_word_q <= pc_word_q;
    end
  end

  // Even-byte outputs keep every instruction on a word boundary
  assign pm_addr      = {pc_word_q, 1'b0};
  assign push_addr    = {push_word_q, 1'b0};
  assign tbl_addr     = table_pointer_q;
  assign tbl_rd_en    = tbl_rd_en_q;
  assign tbl_wr_en    = tbl_wr_en_q;
  assign tbl_wdata    = table_latch_q;
  assign dm_addr      = dm_addr_q;
  assign dm_rd_en     = dm_rd_en_q;
  assign dm_wr_en     = dm_wr_en_q;
  assign dm_wdata     = dm_wdata_q;
  assign stack_push   = push_q;
  assign stack_pop    = pop_q;
  assign phase_strobe = strobe_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_phase_order: assert property (@(posedge core_clk) disable iff (rst)
    at_four |=> at_one ##1 at_two ##1 at_three ##1 at_four) else $error("phase order broken");
  a_pc_when: assert property (@(posedge core_clk) disable iff (rst)
    !at_four |=> $stable(pc_word_q) && $stable(ir_q)) else $error("pc or ir moved off phase four");
  a_pc_step: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && !flow) |=> pc_word_q == $past(pc_word_q) + 20'h00001) else $error("pc did not step one word");
  a_flush_nop: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && flush) |=> (ir_q == NOP_WORD && !dm_wr_en_q && !dm_rd_en_q)[*4]) else $error("flushed word acted");
  a_rd_phase: assert property (@(posedge core_clk) disable iff (rst)
    dm_rd_en_q |-> at_two && $past(at_one)) else $error("data read outside phase two");
  a_wr_phase: assert property (@(posedge core_clk) disable iff (rst)
    dm_wr_en_q |-> at_four && dm_addr_q == $past(wr_addr)) else $error("data write outside phase four");
  a_jump_word: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && jump_sec) |=> pc_word_q == {$past(ir_q[11:0]), $past(pend_lit_q)}) else $error("jump target wrong");
  a_bra_words: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && is_bra) |=> pc_word_q == $past(pc_word_q) + $past(bra_offset)) else $error("branch offset wrong");
  a_lone_second: assert property (@(posedge core_clk) disable iff (rst)
    (at_one && sec_word && !pend_q) |-> ##3 (!dm_wr_en_q && !flow && !push_q)) else $error("lone second word acted");
  a_latch_keep: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && low_write) |=> $stable(pch_q) && $stable(pcu_q)) else $error("computed jump touched latches");
  a_latch_load: assert property (@(posedge core_clk) disable iff (rst)
    (at_two && low_read) |=> pch_q == $past(pc_word_q[14:7])) else $error("latch not refreshed");
  a_return_literal: assert property (@(posedge core_clk) disable iff (rst)
    (at_four && is_ret_lit) |=> w_q == $past(ir_q[7:0]) && pc_word_q == $past(pop_addr[20:1]))
    else $error("return with literal wrong");

endmodule

// [tb/mem_model.sv]
// Program memory, data memory and return stack facing the fetch pipeline.
// Assumes every access except the program fetch is strobed for one phase on core_clk.
`timescale 1ns/1ps

module mem_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Program and table side
  input  wire logic [20:0] pm_addr,
  output logic      [15:0] pm_rdata,
  input  wire logic [20:0] tbl_addr,
  input  wire logic        tbl_rd_en,
  output logic      [7:0]  tbl_rdata,
  input  wire logic        tbl_wr_en,
  input  wire logic [7:0]  tbl_wdata,
  // Data side
  input  wire logic [11:0] dm_addr,
  input  wire logic        dm_rd_en,
  output logic      [7:0]  dm_rdata,
  input  wire logic        dm_wr_en,
  input  wire logic [7:0]  dm_wdata,
  // Return stack
  input  wire logic        stack_push,
  input  wire logic [20:0] push_addr,
  input  wire logic        stack_pop,
  output logic      [20:0] pop_addr
);
  logic [7:0]  pmem [0:1023];
  logic [7:0]  dmem [0:4095];
  logic [20:0] stk  [0:31];
  logic [4:0]  sp_q;
  logic [7:0]  junk_q;

  initial begin
    junk_q = 8'hA5;
    for (int i = 0; i < 1024; i++)
      pmem[i] = 8'h00;
    for (int i = 0; i < 4096; i++)
      dmem[i] = 8'h00;
  end

  // ---------------------------------------------------------------
  // Read paths
  // ---------------------------------------------------------------
  // Only 1 KiB is modelled, so higher addresses alias
  assign pm_rdata  = {pmem[{pm_addr[9:1], 1'b1}], pmem[{pm_addr[9:1], 1'b0}]};
  // Idle lines carry a moving pattern so a late sample cannot pass by luck
  assign tbl_rdata = tbl_rd_en ? pmem[tbl_addr[9:0]] : junk_q;
  assign dm_rdata  = dm_rd_en ? dmem[dm_addr] : ~junk_q;
  assign pop_addr  = (stack_pop && sp_q != 5'd0) ? stk[sp_q - 5'd1] : {13'h0, junk_q};

  // ---------------------------------------------------------------
  // Writes and stack
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    junk_q <= junk_q + 8'h5B;
    if (dm_wr_en)
      dmem[dm_addr] <= dm_wdata;
    if (tbl_wr_en)
      pmem[tbl_addr[9:0]] <= tbl_wdata;
    if (rst)
      sp_q <= 5'd0;
    else if (stack_push) begin
      stk[sp_q] <= push_addr;
      sp_q      <= sp_q + 5'd1;
    end else if (stack_pop && sp_q != 5'd0)
      sp_q <= sp_q - 5'd1;
  end
endmodule

// [tb/tb.sv]
// Self-checking bench: runs a small program through the fetch pipeline.
// Assumes mem_model holds the memories; the bench preloads program memory.
`timescale 1ns/1ps

module tb
  import fetch_pipe_pkg::*;
;
  typedef struct {
    logic        push;
    logic [20:0] addr;
    logic [7:0]  data;
  } note_s;

  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  bank_sel = 4'h0;
  logic [20:0] pm_addr, tbl_addr, push_addr, pop_addr, prev_pm;
  logic [15:0] pm_rdata;
  logic [7:0]  tbl_rdata, tbl_wdata, dm_rdata, dm_wdata, r0, r1, r2, r3, r4;
  logic [11:0] dm_addr;
  logic        tbl_rd_en, tbl_wr_en, dm_rd_en, dm_wr_en, stack_push, stack_pop, prev_rst;
  logic [3:0]  phase_strobe, prev_ph, bk;
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed_v;
  note_s       exp_q[$];
  note_s       got;

  always #12.5 core_clk = ~core_clk;

  fetch_pipeline dut (.core_clk, .rst, .pm_addr, .pm_rdata, .tbl_addr, .tbl_rd_en, .tbl_rdata,
    .tbl_wr_en, .tbl_wdata, .bank_sel, .dm_addr, .dm_rd_en, .dm_rdata, .dm_wr_en, .dm_wdata,
    .stack_push, .push_addr, .stack_pop, .pop_addr, .phase_strobe);

  mem_model mem (.core_clk, .rst, .pm_addr, .pm_rdata, .tbl_addr, .tbl_rd_en, .tbl_rdata,
    .tbl_wr_en, .tbl_wdata, .dm_addr, .dm_rd_en, .dm_rdata, .dm_wr_en, .dm_wdata,
    .stack_push, .push_addr, .stack_pop, .pop_addr);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic pw(input logic [9:0] a, input logic [15:0] w);
    mem.pmem[a]         = w[7:0];
    mem.pmem[a + 10'd1] = w[15:8];
  endtask

  task automatic note(input logic p, input logic [20:0] a, input logic [7:0] d);
    exp_q.push_back('{p, a, d});
  endtask

  // ---------------------------------------------------------------
  // Monitor: phases, fetch address, and data writes and stack pushes in order
  // ---------------------------------------------------------------
  always @(negedge core_clk) begin
    if (rst) begin
      check("phase_strobe", phase_strobe, 4'b0001);
    end else if (!prev_rst) begin
      check("phase_strobe", phase_strobe, {prev_ph[2:0], prev_ph[3]});
      if (phase_strobe !== 4'b0001)
        check("pm_addr", pm_addr, prev_pm);
    end
    check("pm_addr_lsb", pm_addr[0], 1'b0);
    if (dm_rd_en === 1'b1)
      check("dm_rd_phase", phase_strobe, 4'b0010);
    if (stack_pop === 1'b1)
      check("pop_phase", phase_strobe, 4'b1000);
    if (dm_wr_en === 1'b1 || stack_push === 1'b1) begin
      if (exp_q.size() == 0)
        check("unplanned_event", 1'b1, 1'b0);
      else begin
        got = exp_q.pop_front();
        check("event_kind", stack_push, got.push);
        check("event_addr", got.push ? push_addr : {9'h0, dm_addr}, got.addr);
        if (!got.push) begin
          check("dm_wdata", dm_wdata, got.data);
          check("dm_wr_phase", phase_strobe, 4'b1000);
        end
      end
    end
    prev_ph  = phase_strobe;
    prev_pm  = pm_addr;
    prev_rst = rst;
  end

  // ---------------------------------------------------------------
  // Program, expected effects and run
  // ---------------------------------------------------------------
  initial begin
    seed_v = $urandom(32'h72BA);
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    r3 = 8'($urandom);
    r4 = 8'($urandom);
    bk = 4'($urandom);
    @(posedge core_clk);
    bank_sel <= bk;
    pw(10'h000, {8'h0E, r0});
    pw(10'h002, 16'h6E20);
    note(1'b0, 21'h020, r0);
    pw(10'h004, 16'h6F40);
    note(1'b0, {9'h0, bk, 8'h40}, r0);
    pw(10'h006, 16'h2620);
    note(1'b0, 21'h020, r0 + r0);
    pw(10'h008, 16'h0E00);
    pw(10'h00A, 16'h6E23);
    note(1'b0, 21'h023, 8'h00);
    // Zero test skips the first word; the lone second word must do nothing
    pw(10'h00C, 16'h6623);
    pw(10'h00E, 16'hC020);
    pw(10'h010, {SECOND_NIBBLE, 12'h024});
    pw(10'h012, 16'hC020);
    pw(10'h014, {SECOND_NIBBLE, 12'h025});
    note(1'b0, 21'h025, r0 + r0);
    pw(10'h016, 16'hEF80);
    pw(10'h018, 16'hF000);
    pw(10'h01A, 16'h6E26);
    pw(10'h100, 16'h0E05);
    pw(10'h102, 16'h6EFA);
    pw(10'h104, 16'h0E04);
    pw(10'h106, 16'hECA0);
    pw(10'h108, 16'hF000);
    note(1'b1, 21'h10A, 8'h00);
    pw(10'h10A, 16'h6E21);
    note(1'b0, 21'h021, r1);
    pw(10'h10C, 16'hD039);
    pw(10'h10E, 16'h6E26);
    // Stale high latch is refreshed by the read before the computed jump
    pw(10'h140, 16'h66F9);
    pw(10'h142, 16'h26F9);
    pw(10'h144, 16'h0C11);
    pw(10'h146, 16'h0C22);
    pw(10'h148, {8'h0C, r1});
    pw(10'h14A, 16'h0C33);
    pw(10'h180, 16'h0E03);
    pw(10'h182, 16'h6EF7);
    pw(10'h184, 16'h0E01);
    pw(10'h186, 16'h6EF6);
    pw(10'h188, 16'h0008);
    pw(10'h18A, 16'h0E00);
    pw(10'h18C, 16'h24F5);
    pw(10'h18E, 16'h6E22);
    note(1'b0, 21'h022, r2);
    pw(10'h190, {8'h0E, r3});
    pw(10'h192, 16'h6EF5);
    pw(10'h194, 16'h000C);
    pw(10'h196, 16'hD7FF);
    pw(10'h300, {r2, r4});
    repeat (7) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 1500 && exp_q.size() != 0; i++)
      @(posedge core_clk);
    repeat (40) @(posedge core_clk);
    check("notes_left", exp_q.size(), 0);
    check("table_byte", mem.pmem[10'h301], r3);
    check("table_neighbour", mem.pmem[10'h300], r4);
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule
